// [hw/als_pkg.sv]
// Shared constants, types and helpers for the light sensor serial readout.
package als_pkg;

  // ----------------------------------------------------------------------
  // Clocking and conversion timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned OSC_HZ       = 327_600;
  localparam int unsigned OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam logic [7:0]  OSC_DIV_LAST = 8'(OSC_DIV - 1);
  localparam logic [15:0] SELF_LAST    = 16'h7fff;
  localparam logic [15:0] SELF_CYCLES  = 16'h8000;

  // ----------------------------------------------------------------------
  // Serial bus
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h44;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] RELEASED      = 8'hff;
  localparam logic [2:0] AVAIL_SELF    = 3'h2;
  localparam logic [2:0] AVAIL_EXT     = 3'h4;
  localparam logic [2:0] IDX_MAX       = 3'h7;

  // ----------------------------------------------------------------------
  // Commands and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PDOWN    = 8'h8c;
  localparam logic [7:0] CMD_RESET    = 8'h0c;
  localparam logic [7:0] CMD_INT_VIS  = 8'h00;
  localparam logic [7:0] CMD_INT_IR   = 8'h04;
  localparam logic [7:0] CMD_INT_DIFF = 8'h08;
  localparam logic [7:0] CMD_EXT_VIS  = 8'h30;
  localparam logic [7:0] CMD_EXT_IR   = 8'h34;
  localparam logic [7:0] CMD_EXT_DIFF = 8'h38;
  localparam logic [7:0] CMD_RST_VAL  = 8'h00;
  localparam logic [15:0] DATA_RST_VAL = 16'h0000;

  // ----------------------------------------------------------------------
  // Accumulator shape
  // ----------------------------------------------------------------------
  localparam int ACC_W   = 34;
  localparam int RES_LSB = 15;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] result;
  } data_bytes_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic sda;
  } bus_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b011,
    ST_WRITE     = 3'b010,
    ST_WRITE_ACK = 3'b110,
    ST_READ      = 3'b111,
    ST_READ_ACK  = 3'b101
  } i2c_state_t;

  function automatic logic is_ext(input logic [7:0] c);
    return (c == CMD_EXT_VIS) || (c == CMD_EXT_IR) || (c == CMD_EXT_DIFF);
  endfunction : is_ext

  function automatic logic is_self(input logic [7:0] c);
    return (c == CMD_INT_VIS) || (c == CMD_INT_IR) || (c == CMD_INT_DIFF);
  endfunction : is_self

  function automatic logic is_loop(input logic [7:0] c);
    return c[7] && (c != CMD_PDOWN);
  endfunction : is_loop

endpackage : als_pkg

// [hw/i2c_pin_sync.sv]
// Pin synchroniser and bus event detector for the serial clock and data lines.
`timescale 1ns/1ns
module i2c_pin_sync
  import als_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output bus_ev_t   ev
);

  // ----------------------------------------------------------------------
  // Two-stage synchronisers plus one history stage
  // ----------------------------------------------------------------------
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;

  always_comb begin
    scl_d = {scl_q[1:0], scl};
    sda_d = {sda_q[1:0], sda_i};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // The clock line is only ever an input here; the master alone drives it.
  always_comb begin
    ev.rise  = scl_q[1] & ~scl_q[2];
    ev.fall  = ~scl_q[1] & scl_q[2];
    ev.start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    ev.stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    ev.sda   = sda_q[1];
  end

  a_cond_no_edge : assert property (@(posedge clk) disable iff (!rst_n)
    (ev.start || ev.stop) |-> !ev.rise && !ev.fall)
    else $error("Start or stop seen together with a clock edge.");

endmodule : i2c_pin_sync

// [hw/osc_cycle_counter.sv]
// Conversion oscillator enable and its 16-bit cycle counter.
`timescale 1ns/1ns
module osc_cycle_counter
  import als_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  output logic             tick,
  output logic [15:0]      cnt
);

  // ----------------------------------------------------------------------
  // Divider and counter
  // ----------------------------------------------------------------------
  logic [7:0]  div_q, div_d;
  logic        tick_d;
  logic [15:0] cnt_d;

  // The divider never stops, so a clear only rebases the count.
  always_comb begin
    div_d  = (div_q == OSC_DIV_LAST) ? 8'h00 : 8'(div_q + 8'h01);
    tick_d = (div_q == OSC_DIV_LAST);
    if (clr) begin
      cnt_d = 16'h0000;
    end else if (tick) begin
      cnt_d = 16'(cnt + 16'h0001);
    end else begin
      cnt_d = cnt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      tick  <= 1'b0;
      cnt   <= 16'h0000;
    end else begin
      div_q <= div_d;
      tick  <= tick_d;
      cnt   <= cnt_d;
    end
  end

  a_cnt_step : assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !clr) |=> cnt == 16'($past(cnt) + 16'h0001))
    else $error("Cycle counter did not advance on an oscillator tick.");

endmodule : osc_cycle_counter

// [hw/als_i2c_readout.sv]
// Serial slave, command register and integration control of the light sensor.
`timescale 1ns/1ns
//
// Behaviour
// - One 8-bit command register, held until the next write replaces it.
// - Four readable bytes: conversion result pair, then cycle count pair.
// - Answers only slave address 1000100; the master must use it.
// - Master always drives the clock; data driven by whichever side sends.
// - Start, then address and direction byte; receiver pulls data low to acknowledge.
// - Master closes every transaction with a stop: data rises while clock high.
// - Every write replaces the command, and the mode changes at once.
// - A read returns two or four bytes, chosen by the active mode; in loopback every byte read returns the command.
// - No internal pointer; a write carries no sub-address before the command.
// - Every read starts at the first byte and ascends through available bytes.
// - Self-timed 00, 04, 08 convert visible, infrared or difference over 100 ms; 08 takes two such periods.
// - External 30, 34, 38; each repeated same command ends and restarts integration.
// - Any command with top bit set except 8c (power down) is loopback; reads return the written byte.
// - Result sent low byte then high byte; count follows in the same order.
// - A 16-bit counter advances on every conversion oscillator cycle in self-timed and external modes; other modes hold it at zero.
// - At each external period end the counter is latched into the third and fourth bytes.
// - Self-timed modes offer no count; bytes after the result are not acknowledged.
// - Self-timed integration lasts exactly 32768 oscillator cycles per phase; 08 runs two phases.
module als_i2c_readout
  import als_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [15:0] visible_ir_photocurrent,
  input  wire logic [15:0] ir_photocurrent,
  output logic             power_down,
  output logic             loopback_mode
);

  // ----------------------------------------------------------------------
  // Pin events and conversion oscillator
  // ----------------------------------------------------------------------
  bus_ev_t     ev;
  logic        tick;
  logic [15:0] cyc;
  logic        cnt_clr;

  i2c_pin_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .scl   (scl),
    .sda_i (sda_i),
    .ev    (ev)
  );

  osc_cycle_counter u_osc (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (cnt_clr),
    .tick  (tick),
    .cnt   (cyc)
  );

  // ----------------------------------------------------------------------
  // Serial slave state
  // ----------------------------------------------------------------------
  i2c_state_t  state_q, state_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [2:0]  idx_q, idx_d;
  logic        oe_q, oe_d;
  logic        rd_q, rd_d;
  logic [7:0]  cmd_q, cmd_d;
  data_bytes_t snap_q, snap_d;
  logic        cmd_wr;
  logic [7:0]  tx;
  logic [15:0] result_q, result_d;
  logic [15:0] count_q, count_d;

  function automatic logic [2:0] avail(input logic [7:0] c);
    return is_ext(c) ? AVAIL_EXT : AVAIL_SELF;
  endfunction : avail

  function automatic logic [7:0] tx_byte(input logic [2:0] i, input data_bytes_t s,
                                         input logic [7:0] c);
    logic [7:0] b;
    b = RELEASED;
    if (is_loop(c)) begin
      b = c;
    end else if (i < avail(c)) begin
      case (i[1:0])
        2'd0: b = s.result[7:0];
        2'd1: b = s.result[15:8];
        2'd2: b = s.count[7:0];
        2'd3: b = s.count[15:8];
      endcase
    end
    return b;
  endfunction : tx_byte

  function automatic logic [2:0] next_idx(input logic [2:0] i);
    return (i == IDX_MAX) ? i : 3'(i + 3'h1);
  endfunction : next_idx

  assign tx = tx_byte(idx_q, snap_q, cmd_q);

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    idx_d   = idx_q;
    oe_d    = oe_q;
    rd_d    = rd_q;
    cmd_d   = cmd_q;
    snap_d  = snap_q;
    cmd_wr  = 1'b0;
    if (ev.stop) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else if (ev.start) begin
      state_d = ST_ADDR;
      bit_d   = 4'h0;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WRITE: begin
          if (ev.rise) begin
            sh_d  = {sh_q[6:0], ev.sda};
            bit_d = 4'(bit_q + 4'h1);
          end else if (ev.fall && bit_q == BITS_PER_BYTE) begin
            if (state_q == ST_WRITE) begin
              cmd_d   = sh_q;
              cmd_wr  = 1'b1;
              state_d = ST_WRITE_ACK;
              oe_d    = 1'b1;
            end else if (sh_q[7:1] == SLAVE_ADDR) begin
              state_d = ST_ADDR_ACK;
              oe_d    = 1'b1;
              rd_d    = sh_q[0];
              idx_d   = 3'h0;
              if (sh_q[0]) begin
                snap_d.result = result_q;
                snap_d.count  = count_q;
              end
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_WRITE_ACK: begin
          if (ev.fall) begin
            state_d = ST_WRITE;
            bit_d   = 4'h0;
            oe_d    = 1'b0;
          end
        end
        ST_ADDR_ACK, ST_READ_ACK: begin
          if (ev.rise && state_q == ST_READ_ACK && ev.sda) begin
            state_d = ST_IDLE;
          end else if (ev.fall) begin
            bit_d = 4'h0;
            if (rd_q) begin
              state_d = ST_READ;
              sh_d    = tx;
              oe_d    = ~tx[7];
              idx_d   = next_idx(idx_q);
            end else begin
              state_d = ST_WRITE;
              oe_d    = 1'b0;
            end
          end
        end
        ST_READ: begin
          if (ev.rise) begin
            bit_d = 4'(bit_q + 4'h1);
          end else if (ev.fall) begin
            if (bit_q == BITS_PER_BYTE) begin
              state_d = ST_READ_ACK;
              oe_d    = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b1};
              oe_d = ~sh_q[6];
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      idx_q   <= 3'h0;
      oe_q    <= 1'b0;
      rd_q    <= 1'b0;
      cmd_q   <= CMD_RST_VAL;
      snap_q  <= '0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      idx_q   <= idx_d;
      oe_q    <= oe_d;
      rd_q    <= rd_d;
      cmd_q   <= cmd_d;
      snap_q  <= snap_d;
    end
  end

  // ----------------------------------------------------------------------
  // Integration control
  // ----------------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_q, acc_d, term;
  logic                    phase_q, phase_d;

  // The difference wraps if one phase saturates the field; full scale is the user's limit.
  always_comb begin
    term = '0;
    if (cmd_q == CMD_INT_DIFF) begin
      term = phase_q ? ACC_W'(visible_ir_photocurrent) : -ACC_W'(ir_photocurrent);
    end else if (cmd_q == CMD_EXT_DIFF) begin
      term = ACC_W'(visible_ir_photocurrent) - ACC_W'(ir_photocurrent);
    end else if (cmd_q == CMD_INT_IR || cmd_q == CMD_EXT_IR) begin
      term = ACC_W'(ir_photocurrent);
    end else begin
      term = ACC_W'(visible_ir_photocurrent);
    end
  end

  always_comb begin
    acc_d    = acc_q;
    phase_d  = phase_q;
    result_d = result_q;
    count_d  = count_q;
    cnt_clr  = 1'b0;
    if (cmd_wr) begin
      if (sh_q == CMD_RESET) begin
        result_d = DATA_RST_VAL;
        count_d  = DATA_RST_VAL;
      end else if (is_ext(sh_q) && sh_q == cmd_q) begin
        result_d = acc_q[RES_LSB+15:RES_LSB];
        count_d  = cyc;
      end
      acc_d   = '0;
      phase_d = 1'b0;
      cnt_clr = 1'b1;
    end else if (!is_self(cmd_q) && !is_ext(cmd_q)) begin
      acc_d   = '0;
      cnt_clr = 1'b1;
    end else if (tick) begin
      acc_d = acc_q + term;
      if (is_self(cmd_q) && cyc == SELF_LAST) begin
        cnt_clr = 1'b1;
        if (cmd_q == CMD_INT_DIFF && !phase_q) begin
          phase_d = 1'b1;
        end else begin
          result_d = acc_d[RES_LSB+15:RES_LSB];
          count_d  = SELF_CYCLES;
          acc_d    = '0;
          phase_d  = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q         <= '0;
      phase_q       <= 1'b0;
      result_q      <= DATA_RST_VAL;
      count_q       <= DATA_RST_VAL;
      sda_o         <= 1'b0;
      sda_oe        <= 1'b0;
      power_down    <= 1'b0;
      loopback_mode <= 1'b0;
    end else begin
      acc_q         <= acc_d;
      phase_q       <= phase_d;
      result_q      <= result_d;
      count_q       <= count_d;
      sda_o         <= 1'b0;
      sda_oe        <= oe_d;
      power_down    <= (cmd_d == CMD_PDOWN);
      loopback_mode <= is_loop(cmd_d);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_byte;
    state_q == ST_ADDR && ev.fall && !ev.stop && !ev.start && bit_q == BITS_PER_BYTE;
  endsequence

  sequence s_first_load;
    state_q == ST_ADDR_ACK && rd_q && ev.fall && !ev.stop && !ev.start;
  endsequence

  a_addr_ack : assert property (s_addr_byte ##0 sh_q[7:1] == SLAVE_ADDR |=>
    sda_oe && state_q == ST_ADDR_ACK)
    else $error("Own address not acknowledged.");
  a_addr_foreign : assert property (s_addr_byte ##0 sh_q[7:1] != SLAVE_ADDR |=>
    !sda_oe && state_q == ST_IDLE)
    else $error("Foreign address was answered.");
  a_cmd_stable : assert property (!cmd_wr |=> $stable(cmd_q))
    else $error("Command changed without a write.");
  a_cmd_write : assert property (cmd_wr |=> cmd_q == $past(sh_q) && sda_oe)
    else $error("Written byte not taken or not acknowledged.");
  a_stop_idle : assert property (ev.stop |=> state_q == ST_IDLE && !sda_oe)
    else $error("Stop did not release the bus.");
  a_read_snap : assert property (s_addr_byte ##0 sh_q == {SLAVE_ADDR, 1'b1} |=>
    snap_q.result == $past(result_q) && snap_q.count == $past(count_q) && idx_q == 3'h0)
    else $error("Read did not snapshot the data bytes.");
  a_first_byte : assert property (s_first_load ##0 !is_loop(cmd_q) |=>
    sh_q == $past(snap_q.result[7:0]) && idx_q == 3'h1)
    else $error("First byte read is not the low result byte.");
  a_loop_echo : assert property (s_first_load ##0 is_loop(cmd_q) |=> sh_q == $past(cmd_q))
    else $error("Loopback read did not return the command.");
  a_self_nak : assert property (state_q == ST_READ && idx_q > AVAIL_SELF && is_self(cmd_q)
    |-> !sda_oe)
    else $error("Self-timed mode drove data past the result.");
  a_pdown_hold : assert property (cmd_q == CMD_PDOWN && !cmd_wr |=> $stable(result_q) && acc_q == '0)
    else $error("Converter ran while powered down.");
  a_self_len : assert property (tick && !cmd_wr && cmd_q == CMD_INT_VIS && cyc == SELF_LAST
    |=> count_q == SELF_CYCLES && acc_q == '0)
    else $error("Self-timed period did not close at its last cycle.");
  a_ext_latch : assert property (cmd_wr && is_ext(sh_q) && sh_q == cmd_q |=>
    count_q == $past(cyc) && cyc == 16'h0000)
    else $error("Repeated external command did not latch the cycle count.");

endmodule : als_i2c_readout

// [testbench/i2c_master_model.sv]
// Serial bus master model that drives the clock and data pins of the readout block.
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // --------------------------------------------------------------------
  // Bit level
  // --------------------------------------------------------------------
  // The clock stands still high between frames; only the master moves it.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic start_cond();
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_pull = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b0;
    hold(8);
  endtask : stop_cond

  // Data moves two cycles into the low phase and is read late in the high phase.
  task automatic bit_cycle(input logic b, output logic s);
    sda_pull = !b;
    hold(2);
    scl = 1'b1;
    hold(3);
    s = sda;
    hold(1);
    scl = 1'b0;
    hold(2);
  endtask : bit_cycle

  // --------------------------------------------------------------------
  // Byte and transaction level
  // --------------------------------------------------------------------
  task automatic wr_byte(input logic [7:0] v, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(v[i], s);
    bit_cycle(1'b1, nak);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      v[i] = s;
    end
    bit_cycle(last, s);
  endtask : rd_byte

  task automatic write_tx(input logic [6:0] a, input logic [15:0] cmds, input int n, output logic [2:0] naks);
    naks = 3'h7;
    start_cond();
    wr_byte({a, 1'b0}, naks[0]);
    for (int i = 0; i < n; i++) wr_byte(cmds[8*i +: 8], naks[i+1]);
    stop_cond();
  endtask : write_tx

  task automatic read_tx(input logic [6:0] a, input int n, output logic nak, output logic [39:0] d);
    d = 40'h0;
    start_cond();
    wr_byte({a, 1'b1}, nak);
    for (int i = 0; i < n; i++) rd_byte(i == n - 1, d[8*i +: 8]);
    stop_cond();
  endtask : read_tx
endmodule : i2c_master_model

// [testbench/als_i2c_readout_tb.sv]
// Self-checking bench for the light sensor serial command and readout block.
`timescale 1ns/1ns
module als_i2c_readout_tb
  import als_pkg::*;
;
  localparam int CEILING = 70000;
  localparam int MS_CLK  = 50000;
  logic        clk;
  logic        rst_n;
  logic        scl;
  logic        sda_pull;
  logic        sda_o;
  logic        sda_oe;
  wire logic   sda;
  logic [15:0] vis_cur;
  logic [15:0] ir_cur;
  logic        power_down;
  logic        loopback_mode;
  logic [2:0]  naks;
  logic        nak;
  logic [39:0] d;
  int          mismatches;
  int          checked;
  int          cycles;

  // --------------------------------------------------------------------
  // Pins, clock and timeout
  // --------------------------------------------------------------------
  // The data line has a pull-up, so a released line reads high.
  assign sda = !((sda_oe && !sda_o) || sda_pull);

  i2c_master_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  als_i2c_readout dut_u (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .visible_ir_photocurrent(vis_cur), .ir_photocurrent(ir_cur),
    .power_down(power_down), .loopback_mode(loopback_mode)
  );

  initial clk = 1'b0;
  always #10 clk = !clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      mismatches++;
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    cmp_flag(power_down, 1'b0);
    cmp_flag(loopback_mode, 1'b0);
    m_u.read_tx(SLAVE_ADDR, 3, nak, d);
    cmp_flag(nak, 1'b0);
    cmp_byte(d[7:0], 8'h00);
    cmp_byte(d[15:8], 8'h00);
    cmp_byte(d[23:16], RELEASED);
    cmp_flag(sda_o, 1'b0);
    cmp_flag(sda_oe, 1'b0);
  endtask : t_reset

  task automatic t_foreign();
    m_u.write_tx(7'h45, 16'h00a5, 1, naks);
    cmp_flag(naks[0], 1'b1);
    cmp_flag(loopback_mode, 1'b0);
  endtask : t_foreign

  // Two commands in one write: the second is a command, not a sub-address.
  task automatic t_loop();
    m_u.write_tx(SLAVE_ADDR, 16'h5aa5, 2, naks);
    cmp_flag(naks[0], 1'b0);
    cmp_flag(naks[2], 1'b0);
    cmp_flag(loopback_mode, 1'b0);
    m_u.write_tx(SLAVE_ADDR, 16'h00a5, 1, naks);
    cmp_flag(loopback_mode, 1'b1);
    m_u.read_tx(SLAVE_ADDR, 3, nak, d);
    for (int i = 0; i < 3; i++) cmp_byte(d[8*i +: 8], 8'ha5);
  endtask : t_loop

  task automatic t_pdown();
    m_u.write_tx(SLAVE_ADDR, {8'h00, CMD_PDOWN}, 1, naks);
    cmp_flag(power_down, 1'b1);
    cmp_flag(loopback_mode, 1'b0);
    m_u.write_tx(SLAVE_ADDR, {8'h00, CMD_RESET}, 1, naks);
    cmp_flag(power_down, 1'b0);
    m_u.read_tx(SLAVE_ADDR, 2, nak, d);
    cmp_byte(d[7:0], 8'h00);
    cmp_byte(d[15:8], 8'h00);
  endtask : t_pdown

  // With a visible level of 8000 the result equals the tick count of its period.
  task automatic t_ext();
    int          c0;
    int          e;
    logic [15:0] cnt;
    // Both writes reach their command byte at the same offset, so start to start is the period.
    c0 = cycles;
    m_u.write_tx(SLAVE_ADDR, {8'h00, CMD_EXT_VIS}, 1, naks);
    repeat (MS_CLK) @(posedge clk);
    #1;
    e = cycles - c0;
    m_u.write_tx(SLAVE_ADDR, {8'h00, CMD_EXT_VIS}, 1, naks);
    m_u.read_tx(SLAVE_ADDR, 5, nak, d);
    cnt = {d[31:24], d[23:16]};
    cmp_flag(cnt >= 16'(e / 152 - 1) && cnt <= 16'(e / 152 + 1), 1'b1);
    cmp_byte(d[7:0], d[23:16]);
    cmp_byte(d[15:8], d[31:24]);
    cmp_byte(d[39:32], RELEASED);
  endtask : t_ext

  // A switch to a self-timed mode keeps the stored result but drops the count.
  task automatic t_self();
    logic [15:0] res;
    res = d[15:0];
    m_u.write_tx(SLAVE_ADDR, {8'h00, CMD_INT_IR}, 1, naks);
    m_u.read_tx(SLAVE_ADDR, 3, nak, d);
    cmp_byte(d[7:0], res[7:0]);
    cmp_byte(d[15:8], res[15:8]);
    cmp_byte(d[23:16], RELEASED);
  endtask : t_self

  initial begin
    mismatches = 0;
    checked    = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    vis_cur    = 16'h8000;
    ir_cur     = 16'h1234;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_foreign();
    t_loop();
    t_pdown();
    t_ext();
    t_self();
    close_out();
  end
endmodule : als_i2c_readout_tb
